// File: ofd_pkg.sv
`default_nettype none
package ofd_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PC_W = 21;
  localparam int unsigned FADDR_W = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned NFLAGS = 5;
  localparam int unsigned APB_AW = 8;

  // Register byte addresses
  localparam logic [7:0] REG_BANK = 8'h00;
  localparam logic [7:0] REG_TPTR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0c;
  localparam logic [7:0] REG_LAST = 8'h10;

  // Status flag positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_HC = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_OVF = 3;
  localparam int unsigned FLG_N = 4;

  // Top nibble groups and sub-codes
  localparam logic [3:0] NIB_MISC = 4'h0;
  localparam logic [3:0] NIB_BYTE_LO = 4'h1;
  localparam logic [3:0] NIB_BYTE_HI = 4'h6;
  localparam logic [3:0] NIB_BIT_LO = 4'h7;
  localparam logic [3:0] NIB_BIT_HI = 4'hb;
  localparam logic [3:0] NIB_MOVFF = 4'hc;
  localparam logic [3:0] NIB_REL = 4'hd;
  localparam logic [3:0] NIB_EXT = 4'he;
  localparam logic [3:0] NIB_SECOND = 4'hf;
  localparam logic [3:0] EXT_CALL0 = 4'hc;
  localparam logic [3:0] EXT_CALL1 = 4'hd;
  localparam logic [3:0] EXT_GOTO = 4'hf;
  localparam logic [3:0] EXT_LFSR = 4'he;
  localparam logic [3:0] EXT_MOVSS = 4'hb;
  localparam logic [7:0] MISC_HI_ZERO = 8'h00;
  localparam logic [5:0] MISC_TBL = 6'h02;
  localparam logic [5:0] MISC_RET = 6'h04;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

  typedef enum logic [1:0] {TBL_KEEP, TBL_POST_INC, TBL_POST_DEC, TBL_PRE_INC} ofd_tbl_mode_t;
  typedef enum logic [1:0] {LIT_NONE, LIT_8, LIT_12, LIT_20} ofd_lit_w_t;
  typedef enum logic [3:0] {
    CL_OTHER, CL_BYTE, CL_BIT, CL_BRC, CL_BRA, CL_RCALL, CL_CALL, CL_GOTO,
    CL_MOVFF, CL_MOVSS, CL_LFSR, CL_LIT8, CL_TBL, CL_RET, CL_SECOND
  } ofd_class_t;

  // Access RAM ignores the bank selector; banked access prefixes it
  function automatic logic [FADDR_W-1:0] ofd_file_addr(input logic a, input logic [7:0] f,
                                                       input logic [BANK_W-1:0] bank);
    logic [BANK_W-1:0] hi;
    hi = '0;
    if (a) begin
      hi = bank;
    end else if (f >= ACCESS_SPLIT) begin
      hi = ACCESS_HI_BANK;
    end
    return {hi, f};
  endfunction

  function automatic logic [PC_W-1:0] ofd_rel_target(input logic [PC_W-1:0] pc,
                                                     input logic [PC_W-1:0] off);
    return pc + PC_STEP + {off[PC_W-2:0], 1'b0};
  endfunction
endpackage
`default_nettype wire

// File: ofd_field_extract.sv
`timescale 1ns/1ps
`default_nettype none
module ofd_field_extract (
  input wire logic [15:0] word,
  output ofd_pkg::ofd_class_t cls,
  output logic [7:0] f8,
  output logic dest_sel,
  output logic access_sel,
  output logic [2:0] bit_num,
  output logic [1:0] ptr_sel,
  output logic [11:0] f12,
  output logic [7:0] k8,
  output logic [20:0] n8_ext,
  output logic [20:0] n11_ext,
  output logic [1:0] tbl_mode,
  output logic tbl_write,
  output logic fast_sel,
  output logic [6:0] z7,
  output logic [2:0] cond
);
  logic [3:0] nib;
  logic [3:0] sub;

  assign nib = word[15:12];
  assign sub = word[11:8];
  assign f8 = word[7:0];
  assign dest_sel = word[9];
  assign access_sel = word[8];
  assign bit_num = word[11:9];
  assign ptr_sel = word[5:4];
  assign f12 = word[11:0];
  assign k8 = word[7:0];
  assign n8_ext = {{13{word[7]}}, word[7:0]};
  assign n11_ext = {{10{word[10]}}, word[10:0]};
  assign tbl_mode = word[1:0];
  assign tbl_write = word[2];
  assign fast_sel = word[0];
  assign z7 = word[6:0];
  assign cond = word[10:8];

  // Only bits that select an operation are compared; don't-care bits are never looked at
  always_comb begin
    cls = ofd_pkg::CL_OTHER;
    if (nib == ofd_pkg::NIB_MISC) begin
      if (word[11]) begin
        cls = ofd_pkg::CL_LIT8;
      end else if (word[11:4] == ofd_pkg::MISC_HI_ZERO && word[3:2] == ofd_pkg::MISC_TBL[1:0]) begin
        cls = ofd_pkg::CL_TBL;
      end else if (word[11:4] == ofd_pkg::MISC_HI_ZERO && word[3:2] == ofd_pkg::MISC_TBL[1:0] + 2'h1) begin
        cls = ofd_pkg::CL_TBL;
      end else if (word[11:2] == {4'h0, ofd_pkg::MISC_RET}) begin
        cls = ofd_pkg::CL_RET;
      end
    end else if (nib >= ofd_pkg::NIB_BYTE_LO && nib <= ofd_pkg::NIB_BYTE_HI) begin
      cls = ofd_pkg::CL_BYTE;
    end else if (nib >= ofd_pkg::NIB_BIT_LO && nib <= ofd_pkg::NIB_BIT_HI) begin
      cls = ofd_pkg::CL_BIT;
    end else if (nib == ofd_pkg::NIB_MOVFF) begin
      cls = ofd_pkg::CL_MOVFF;
    end else if (nib == ofd_pkg::NIB_REL) begin
      cls = word[11] ? ofd_pkg::CL_RCALL : ofd_pkg::CL_BRA;
    end else if (nib == ofd_pkg::NIB_EXT) begin
      if (!word[11]) begin
        cls = ofd_pkg::CL_BRC;
      end else if (sub == ofd_pkg::EXT_CALL0 || sub == ofd_pkg::EXT_CALL1) begin
        cls = ofd_pkg::CL_CALL;
      end else if (sub == ofd_pkg::EXT_GOTO) begin
        cls = ofd_pkg::CL_GOTO;
      end else if (sub == ofd_pkg::EXT_LFSR && word[7:6] == 2'h0) begin
        cls = ofd_pkg::CL_LFSR;
      end else if (sub == ofd_pkg::EXT_MOVSS && word[7]) begin
        cls = ofd_pkg::CL_MOVSS;
      end
    end else if (nib == ofd_pkg::NIB_SECOND) begin
      cls = ofd_pkg::CL_SECOND;
    end
  end
endmodule
`default_nettype wire

// File: ofd_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module ofd_status_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [4:0] upd_mask,
  input wire logic [4:0] upd_val,
  input wire logic [2:0] cond,
  output logic [4:0] flags,
  output logic cond_true
);
  typedef struct packed {
    logic [4:0] flags;
  } ofd_flag_state_t;

  ofd_flag_state_t st_q;
  ofd_flag_state_t st_d;
  logic sel;

  // Each flag follows the result only where the instruction says it is affected
  always_comb begin
    st_d = st_q;
    st_d.flags = (st_q.flags & ~upd_mask) | (upd_val & upd_mask);
  end

  // Pairs: zero, carry, overflow, negative; odd code is the inverted test
  always_comb begin
    sel = 1'b0;
    case (cond[2:1])
      2'h0: sel = st_q.flags[ofd_pkg::FLG_Z];
      2'h1: sel = st_q.flags[ofd_pkg::FLG_C];
      2'h2: sel = st_q.flags[ofd_pkg::FLG_OVF];
      default: sel = st_q.flags[ofd_pkg::FLG_N];
    endcase
  end

  assign cond_true = sel ^ cond[0];
  assign flags = st_q.flags;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// File: ofd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder #(
  parameter int unsigned BANK_W = ofd_pkg::BANK_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  input wire logic [20:0] return_stack_top,
  input wire logic [4:0] alu_flag_mask,
  input wire logic [4:0] alu_flag_val,
  output logic dec_valid,
  output logic dec_nop,
  output ofd_pkg::ofd_class_t dec_class,
  output logic [11:0] file_addr,
  output logic dest_to_acc,
  output logic [7:0] bit_mask,
  output logic [1:0] indirect_sel,
  output logic [11:0] src_addr,
  output logic [11:0] dst_addr,
  output logic [19:0] literal,
  output ofd_pkg::ofd_lit_w_t literal_width,
  output logic [20:0] table_addr,
  output ofd_pkg::ofd_tbl_mode_t table_mode,
  output logic table_write,
  output logic shadow_save,
  output logic shadow_restore,
  output logic [6:0] src_offset,
  output logic [6:0] dst_offset,
  output logic [20:0] pc_out,
  output logic [4:0] alu_flags
);
  typedef enum logic [1:0] {S_FIRST, S_SECOND, S_FLUSH} ofd_fsm_t;

  typedef struct packed {
    ofd_fsm_t fsm;
    logic [20:0] pc;
    logic [BANK_W-1:0] bank;
    logic [20:0] tptr;
    logic [15:0] w1;
    ofd_pkg::ofd_class_t cls1;
    logic [15:0] last;
    logic dec_valid;
    logic dec_nop;
    ofd_pkg::ofd_class_t dec_class;
    logic [11:0] file_addr;
    logic dest_to_acc;
    logic [7:0] bit_mask;
    logic [1:0] indirect_sel;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [19:0] literal;
    ofd_pkg::ofd_lit_w_t literal_width;
    logic [20:0] table_addr;
    ofd_pkg::ofd_tbl_mode_t table_mode;
    logic table_write;
    logic shadow_save;
    logic shadow_restore;
    logic [6:0] src_offset;
    logic [6:0] dst_offset;
    logic [31:0] rdata;
    logic slverr;
  } ofd_state_t;

  ofd_state_t st_q;
  ofd_state_t st_d;

  ofd_pkg::ofd_class_t x_cls;
  logic [7:0] x_f8;
  logic x_dest;
  logic x_access;
  logic [2:0] x_bit;
  logic [11:0] x_f12;
  logic [7:0] x_k8;
  logic [20:0] x_n8;
  logic [20:0] x_n11;
  logic [1:0] x_tbl;
  logic x_tblw;
  logic x_fast;
  logic [6:0] x_z7;
  logic [2:0] x_cond;
  logic cond_true;
  logic take;
  logic apb_access;

  ofd_field_extract u_extract (
    .word(instr_word),
    .cls(x_cls),
    .f8(x_f8),
    .dest_sel(x_dest),
    .access_sel(x_access),
    .bit_num(x_bit),
    .ptr_sel(),
    .f12(x_f12),
    .k8(x_k8),
    .n8_ext(x_n8),
    .n11_ext(x_n11),
    .tbl_mode(x_tbl),
    .tbl_write(x_tblw),
    .fast_sel(x_fast),
    .z7(x_z7),
    .cond(x_cond)
  );

  ofd_status_flags u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .upd_mask(alu_flag_mask),
    .upd_val(alu_flag_val),
    .cond(x_cond),
    .flags(alu_flags),
    .cond_true(cond_true)
  );

  assign instr_ready = clk_en && st_q.fsm != S_FLUSH;
  assign take = instr_valid && instr_ready;
  assign apb_access = psel && penable && clk_en;

  always_comb begin
    st_d = st_q;
    st_d.dec_valid = 1'b0;
    st_d.shadow_save = 1'b0;
    st_d.shadow_restore = 1'b0;
    case (st_q.fsm)
      S_FLUSH: begin
        // Second cycle of a flow change: a bubble, no word consumed
        st_d.dec_valid = 1'b1;
        st_d.dec_nop = 1'b1;
        st_d.dec_class = ofd_pkg::CL_OTHER;
        st_d.fsm = S_FIRST;
      end
      S_FIRST: begin
        if (take) begin
          st_d.last = instr_word;
          st_d.pc = st_q.pc + ofd_pkg::PC_STEP;
          st_d.dec_class = x_cls;
          st_d.dec_nop = 1'b0;
          st_d.literal_width = ofd_pkg::LIT_NONE;
          st_d.dec_valid = 1'b1;
          case (x_cls)
            ofd_pkg::CL_BYTE: begin
              st_d.file_addr = ofd_pkg::ofd_file_addr(x_access, x_f8, 4'(st_q.bank));
              st_d.dest_to_acc = !x_dest;
            end
            ofd_pkg::CL_BIT: begin
              st_d.file_addr = ofd_pkg::ofd_file_addr(x_access, x_f8, 4'(st_q.bank));
              st_d.bit_mask = 8'h01 << x_bit;
            end
            ofd_pkg::CL_LIT8: begin
              st_d.literal = {12'h000, x_k8};
              st_d.literal_width = ofd_pkg::LIT_8;
            end
            ofd_pkg::CL_BRC: begin
              if (cond_true) begin
                st_d.pc = ofd_pkg::ofd_rel_target(st_q.pc, x_n8);
                st_d.fsm = S_FLUSH;
              end
            end
            ofd_pkg::CL_BRA, ofd_pkg::CL_RCALL: begin
              st_d.pc = ofd_pkg::ofd_rel_target(st_q.pc, x_n11);
              st_d.fsm = S_FLUSH;
            end
            ofd_pkg::CL_RET: begin
              st_d.pc = return_stack_top;
              st_d.shadow_restore = x_fast;
              st_d.fsm = S_FLUSH;
            end
            ofd_pkg::CL_TBL: begin
              st_d.table_mode = ofd_pkg::ofd_tbl_mode_t'(x_tbl);
              st_d.table_write = x_tblw;
              st_d.table_addr = st_q.tptr;
              // Pre-increment presents the bumped pointer in the same slot
              case (ofd_pkg::ofd_tbl_mode_t'(x_tbl))
                ofd_pkg::TBL_POST_INC: st_d.tptr = st_q.tptr + 21'h1;
                ofd_pkg::TBL_POST_DEC: st_d.tptr = st_q.tptr - 21'h1;
                ofd_pkg::TBL_PRE_INC: begin
                  st_d.tptr = st_q.tptr + 21'h1;
                  st_d.table_addr = st_q.tptr + 21'h1;
                end
                default: st_d.tptr = st_q.tptr;
              endcase
            end
            ofd_pkg::CL_CALL, ofd_pkg::CL_GOTO, ofd_pkg::CL_MOVFF,
            ofd_pkg::CL_MOVSS, ofd_pkg::CL_LFSR: begin
              // First half of a two-word operation; output waits for the second word
              st_d.dec_valid = 1'b0;
              st_d.w1 = instr_word;
              st_d.cls1 = x_cls;
              st_d.fsm = S_SECOND;
            end
            ofd_pkg::CL_SECOND: begin
              st_d.dec_nop = 1'b1;
            end
            default: begin
              st_d.dec_nop = 1'b0;
            end
          endcase
        end
      end
      S_SECOND: begin
        if (take) begin
          st_d.last = instr_word;
          st_d.pc = st_q.pc + ofd_pkg::PC_STEP;
          st_d.dec_valid = 1'b1;
          st_d.dec_nop = 1'b0;
          st_d.dec_class = st_q.cls1;
          st_d.fsm = S_FIRST;
          case (st_q.cls1)
            ofd_pkg::CL_MOVFF: begin
              st_d.src_addr = st_q.w1[11:0];
              st_d.dst_addr = x_f12;
            end
            ofd_pkg::CL_MOVSS: begin
              // Upper bits of the second word are don't-care
              st_d.src_offset = st_q.w1[6:0];
              st_d.dst_offset = x_z7;
            end
            ofd_pkg::CL_LFSR: begin
              st_d.indirect_sel = st_q.w1[5:4];
              st_d.literal = {8'h00, st_q.w1[3:0], x_k8};
              st_d.literal_width = ofd_pkg::LIT_12;
            end
            ofd_pkg::CL_CALL, ofd_pkg::CL_GOTO: begin
              st_d.literal = {x_f12, st_q.w1[7:0]};
              st_d.literal_width = ofd_pkg::LIT_20;
              st_d.pc = {x_f12, st_q.w1[7:0], 1'b0};
              st_d.shadow_save = st_q.cls1 == ofd_pkg::CL_CALL && st_q.w1[8];
              st_d.fsm = S_FLUSH;
            end
            default: begin
              st_d.dec_nop = 1'b1;
            end
          endcase
          if (x_cls != ofd_pkg::CL_SECOND && st_q.cls1 != ofd_pkg::CL_MOVSS) begin
            // Second word lacks its marker (except after MOVSS): treat the pair as a no-op rather than guess
            st_d.dec_nop = 1'b1;
            st_d.pc = st_q.pc + ofd_pkg::PC_STEP;
            st_d.fsm = S_FIRST;
          end
        end
      end
      default: st_d.fsm = S_FIRST;
    endcase

    // Register file; software writes land after the core update so they win
    st_d.slverr = 1'b0;
    st_d.rdata = '0;
    if (psel && !penable) begin
      if (paddr == ofd_pkg::REG_BANK) begin
        st_d.rdata = 32'(st_q.bank);
      end else if (paddr == ofd_pkg::REG_TPTR) begin
        st_d.rdata = 32'(st_q.tptr);
      end else if (paddr == ofd_pkg::REG_STATUS) begin
        st_d.rdata = {24'h000000, 1'b0, st_q.fsm, alu_flags};
      end else if (paddr == ofd_pkg::REG_PC) begin
        st_d.rdata = 32'(st_q.pc);
      end else if (paddr == ofd_pkg::REG_LAST) begin
        st_d.rdata = 32'(st_q.last);
      end else begin
        st_d.slverr = 1'b1;
      end
    end else if (apb_access) begin
      st_d.rdata = st_q.rdata;
      st_d.slverr = st_q.slverr;
      if (pwrite) begin
        if (paddr == ofd_pkg::REG_BANK) begin
          st_d.bank = pwdata[BANK_W-1:0];
        end else if (paddr == ofd_pkg::REG_TPTR) begin
          st_d.tptr = pwdata[20:0];
        end else if (paddr == ofd_pkg::REG_PC) begin
          // Forces the sequencer back to a first word; a pending pair is dropped
          st_d.pc = {pwdata[20:1], 1'b0};
          st_d.fsm = S_FIRST;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.pc <= ofd_pkg::PC_RESET;
      st_q.fsm <= S_FIRST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Zero-wait slave: read data is captured in setup, shown in access
  assign pready = 1'b1;
  assign prdata = st_q.rdata;
  assign pslverr = st_q.slverr && psel && penable;
  assign dec_valid = st_q.dec_valid;
  assign dec_nop = st_q.dec_nop;
  assign dec_class = st_q.dec_class;
  assign file_addr = st_q.file_addr;
  assign dest_to_acc = st_q.dest_to_acc;
  assign bit_mask = st_q.bit_mask;
  assign indirect_sel = st_q.indirect_sel;
  assign src_addr = st_q.src_addr;
  assign dst_addr = st_q.dst_addr;
  assign literal = st_q.literal;
  assign literal_width = st_q.literal_width;
  assign table_addr = st_q.table_addr;
  assign table_mode = st_q.table_mode;
  assign table_write = st_q.table_write;
  assign shadow_save = st_q.shadow_save;
  assign shadow_restore = st_q.shadow_restore;
  assign src_offset = st_q.src_offset;
  assign dst_offset = st_q.dst_offset;
  assign pc_out = st_q.pc;
endmodule
`default_nettype wire

// File: ofd_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic [4:0] alu_flag_mask,
  input wire logic [4:0] alu_flag_val,
  input wire logic dec_valid,
  input wire logic dec_nop,
  input var ofd_pkg::ofd_class_t dec_class,
  input wire logic [11:0] file_addr,
  input wire logic dest_to_acc,
  input wire logic [7:0] bit_mask,
  input var ofd_pkg::ofd_tbl_mode_t table_mode,
  input wire logic table_write,
  input wire logic shadow_save,
  input wire logic shadow_restore,
  input wire logic [4:0] alu_flags
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic tk;
  // Dropped pairs decode as nop, so field checks tolerate dec_nop
  assign tk = instr_valid && instr_ready;
  property p_acc;
    tk && instr_word[15:12] inside {[4'h1:4'h6]} && !instr_word[8] && instr_word[7:0] < 8'h60
      |=> dec_valid && (dec_nop || file_addr == {4'h0, $past(instr_word[7:0])});
  endproperty
  a_acc: assert property (p_acc) else $error("access ram address wrong");
  property p_dest;
    tk && instr_word[15:12] inside {[4'h1:4'h6]} |=> dec_valid && (dec_nop || dest_to_acc == !$past(instr_word[9]));
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");
  property p_bit;
    tk && instr_word[15:12] inside {[4'h7:4'hb]}
      |=> dec_valid && (dec_nop || bit_mask == 8'h01 << $past(instr_word[11:9]));
  endproperty
  a_bit: assert property (p_bit) else $error("bit mask wrong");
  property p_tbl;
    tk && instr_word[15:3] == 13'h0001
      |=> dec_nop || (table_mode == $past(instr_word[1:0]) && table_write == $past(instr_word[2]));
  endproperty
  a_tbl: assert property (p_tbl) else $error("table mode wrong");
  property p_ss;
    shadow_save || shadow_restore |-> dec_valid && !(shadow_save && shadow_restore);
  endproperty
  a_ss: assert property (p_ss) else $error("shadow pulse misplaced");
  property p_flg;
    clk_en |=> alu_flags == (($past(alu_flags) & ~$past(alu_flag_mask)) | ($past(alu_flag_val) & $past(alu_flag_mask)));
  endproperty
  a_flg: assert property (p_flg) else $error("flag update wrong");
  property p_bub;
    clk_en && dec_valid && !dec_nop && dec_class inside {ofd_pkg::CL_BRA, ofd_pkg::CL_GOTO, ofd_pkg::CL_CALL}
      |-> !instr_ready ##1 (dec_valid && dec_nop);
  endproperty
  a_bub: assert property (p_bub) else $error("no bubble after jump");
  property p_sec;
    dec_valid && dec_class == ofd_pkg::CL_SECOND |-> dec_nop;
  endproperty
  a_sec: assert property (p_sec) else $error("lone second word not nop");
  c_bub: cover property (dec_valid && dec_nop);
  c_save: cover property (shadow_save);
  c_tbl: cover property (dec_valid && dec_class == ofd_pkg::CL_TBL);
endmodule
`default_nettype wire

// File: ofd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model #(
  parameter logic [20:0] RET_ADDR = 21'h0abcd4
) (
  input wire logic pclk,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [15:0] instr_word,
  output logic [20:0] return_stack_top
);
  logic rdy;
  assign return_stack_top = RET_ADDR;
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h5a5a;
  end
  // Each word is held until an edge with ready high takes it
  task automatic send(input logic [31:0] ws, input bit two);
    @(posedge pclk);
    for (int i = 0; i <= int'(two); i++) begin
      instr_valid <= 1'b1;
      instr_word <= (two && i == 0) ? ws[31:16] : ws[15:0];
      do begin
        @(negedge pclk) rdy = instr_ready;
        @(posedge pclk);
      end while (!rdy);
    end
    instr_valid <= 1'b0;
    // Stale word must not look like the last one
    instr_word <= ~ws[15:0];
  endtask
endmodule
`default_nettype wire

// File: ofd_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [15:0] w; logic [3:0] s; logic [20:0] e;} ofd_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] alu_flag_mask = 5'h00;
  logic [4:0] alu_flag_val = 5'h00;
  logic [31:0] prdata;
  logic pready, pslverr, perr, instr_valid, instr_ready, dec_valid, dec_nop, dest_to_acc;
  logic table_write, shadow_save, shadow_restore;
  logic [15:0] instr_word;
  logic [20:0] return_stack_top, table_addr, pc_out;
  logic [11:0] file_addr, src_addr, dst_addr;
  logic [7:0] bit_mask;
  logic [1:0] indirect_sel;
  logic [19:0] literal;
  logic [6:0] src_offset, dst_offset;
  logic [4:0] alu_flags;
  ofd_pkg::ofd_class_t dec_class;
  ofd_pkg::ofd_lit_w_t literal_width;
  ofd_pkg::ofd_tbl_mode_t table_mode;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] mv [2] = '{32'heb85f0aa, 32'heb85002a};
  ofd_row_t rows [18] = '{
    '{16'h2425, 4'h0, 21'h025}, '{16'h2480, 4'h0, 21'hf80}, '{16'h2525, 4'h0, 21'h325},
    '{16'h2425, 4'h1, 21'h1}, '{16'h2625, 4'h1, 21'h0},
    '{16'h9040, 4'h2, 21'h01}, '{16'h9a40, 4'h2, 21'h20}, '{16'h9e40, 4'h2, 21'h80},
    '{16'h0e5a, 4'h3, 21'h5a}, '{16'h0e5a, 4'h4, 21'(ofd_pkg::LIT_8)},
    '{16'h0008, 4'h7, 21'h1abcde}, '{16'h0008, 4'h5, 21'(ofd_pkg::TBL_KEEP)},
    '{16'h0009, 4'h5, 21'(ofd_pkg::TBL_POST_INC)}, '{16'h000a, 4'h5, 21'(ofd_pkg::TBL_POST_DEC)},
    '{16'h000b, 4'h5, 21'(ofd_pkg::TBL_PRE_INC)}, '{16'h000c, 4'h6, 21'h1}, '{16'h0009, 4'h6, 21'h0},
    '{16'hf0ff, 4'h8, 21'h1}};
  always #25 pclk = ~pclk;
  ofd_decoder DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr_valid, .instr_word, .instr_ready, .return_stack_top, .alu_flag_mask, .alu_flag_val,
    .dec_valid, .dec_nop, .dec_class, .file_addr, .dest_to_acc, .bit_mask, .indirect_sel, .src_addr,
    .dst_addr, .literal, .literal_width, .table_addr, .table_mode, .table_write, .shadow_save,
    .shadow_restore, .src_offset, .dst_offset, .pc_out, .alu_flags);
  ofd_fetch_model fm (.pclk, .instr_ready, .instr_valid, .instr_word, .return_stack_top);
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] ws, input bit two);
    int n;
    fm.send(ws, two);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (dec_valid !== 1'b1 && n < 8);
    chk("dec_valid", 32'(dec_valid), 32'h1);
  endtask
  function automatic logic [20:0] pick(input logic [3:0] s);
    case (s)
      4'h0: return 21'(file_addr);
      4'h1: return 21'(dest_to_acc);
      4'h2: return 21'(bit_mask);
      4'h3: return 21'(literal);
      4'h4: return 21'(literal_width);
      4'h5: return 21'(table_mode);
      4'h6: return 21'(table_write);
      4'h7: return table_addr;
      default: return 21'(dec_nop);
    endcase
  endfunction
  initial begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  initial begin
    logic [31:0] r;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ofd_pkg::REG_BANK, 32'h0, r);
    chk("bank_rst", r, 32'h0);
    apb(1'b0, ofd_pkg::REG_PC, 32'h0, r);
    chk("pc_rst", r, 32'h0);
    apb(1'b1, ofd_pkg::REG_TPTR, 32'hffffffff, r);
    apb(1'b0, ofd_pkg::REG_TPTR, 32'h0, r);
    chk("tptr", r, 32'h001fffff);
    apb(1'b1, ofd_pkg::REG_TPTR, 32'h001abcde, r);
    apb(1'b1, ofd_pkg::REG_BANK, 32'h3, r);
    apb(1'b0, 8'h14, 32'h0, r);
    chk("unmapped", {r[30:0], perr}, 32'h1);
    foreach (rows[i]) begin
      run({16'h0, rows[i].w}, 1'b0);
      chk($sformatf("row%0d", i), 32'(pick(rows[i].s)), 32'(rows[i].e));
    end
    apb(1'b0, ofd_pkg::REG_TPTR, 32'h0, r);
    chk("tptr_step", r, 32'h001abce0);
    @(posedge pclk);
    alu_flag_mask <= 5'h1f;
    alu_flag_val <= 5'h15;
    @(posedge pclk);
    alu_flag_mask <= 5'h02;
    alu_flag_val <= 5'h02;
    @(posedge pclk);
    alu_flag_mask <= 5'h00;
    @(negedge pclk);
    chk("flags", 32'(alu_flags), 32'h17);
    @(posedge pclk);
    clk_en <= 1'b0;
    alu_flag_mask <= 5'h1f;
    @(posedge pclk);
    @(negedge pclk);
    chk("freeze", 32'({alu_flags, instr_ready}), 32'h0000002e);
    @(posedge pclk);
    clk_en <= 1'b1;
    alu_flag_mask <= 5'h00;
    apb(1'b1, ofd_pkg::REG_STATUS, 32'h0, r);
    apb(1'b0, ofd_pkg::REG_STATUS, 32'h0, r);
    chk("status", r & 32'h1f, 32'h17);
    apb(1'b1, ofd_pkg::REG_PC, 32'h100, r);
    run(32'hd7fd, 1'b0);
    chk("bra_pc", 32'({pc_out, instr_ready}), 32'h000001f8);
    @(negedge pclk);
    chk("bra_bubble", 32'({dec_valid, dec_nop}), 32'h3);
    apb(1'b1, ofd_pkg::REG_PC, 32'h200, r);
    run(32'he205, 1'b0);
    chk("bc_pc", 32'(pc_out), 32'h20c);
    apb(1'b1, ofd_pkg::REG_PC, 32'h300, r);
    run(32'he110, 1'b0);
    chk("bnz_ready", 32'({instr_ready, dec_nop}), 32'h2);
    run(32'hef12f345, 1'b1);
    chk("goto_pc", 32'(pc_out), 32'h68a24);
    chk("goto_lit", 32'({literal_width, literal}), {10'h0, 2'(ofd_pkg::LIT_20), 20'h34512});
    run(32'hc123fabc, 1'b1);
    chk("movff", {8'h0, src_addr, dst_addr}, 32'h00123abc);
    chk("movff_cls", 32'(dec_class), 32'(ofd_pkg::CL_MOVFF));
    run(32'hee2af05b, 1'b1);
    chk("lfsr", 32'({indirect_sel, literal_width, literal}), 32'h00a00a5b);
    foreach (mv[i]) begin
      run(mv[i], 1'b1);
      chk("movss", 32'({src_offset, dst_offset}), 32'h000002aa);
    end
    run(32'hed00f000, 1'b1);
    chk("call_fast", 32'(shadow_save), 32'h1);
    run(32'hec00f000, 1'b1);
    chk("call_slow", 32'(shadow_save), 32'h0);
    run(32'h00000013, 1'b0);
    chk("ret_fast", 32'({shadow_restore, pc_out}), {10'h0, 1'b1, 21'h0abcd4});
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ofd_pkg::REG_TPTR, 32'h0, r);
    chk("rst2", r | 32'(pc_out), 32'h0);
    close_out();
  end
endmodule
bind ofd_decoder ofd_decoder_chk u_chk (.pclk, .presetn, .clk_en, .instr_valid, .instr_word, .instr_ready,
  .alu_flag_mask, .alu_flag_val, .dec_valid, .dec_nop, .dec_class, .file_addr, .dest_to_acc, .bit_mask,
  .table_mode, .table_write, .shadow_save, .shadow_restore, .alu_flags);
`default_nettype wire
